// ---- rtl/ccs_clock_ctrl.sv ----
// clock source selection, start-up delays, rc trim and prescaler reset value
//
// Behaviour
// (R01) low-frequency crystal wake: 1K source cycles if select lsb 0, 32K if 1
// (R02) low-frequency crystal reset extra: 14 cycles, plus 4.1 ms or 65 ms
// (R03) select code 0010 runs from the calibrated rc oscillator, the default
// (R04) rc oscillator: wake 6 cycles; reset 14, +4.1 ms, +65 ms; 11 reserved
// (R05) reset pin disabled lengthens internal-oscillator brown-out option to +4.1 ms
// (R06) every reset loads the factory calibration byte into the trim register
// (R07) trim register is 8-bit read/write; writes change the trim at once
// (R08) top trim bit picks low or high range; ranges overlap
// (R09) low seven trim bits tune monotonically inside the chosen range
// (R10) software keeps trim at or below 8.8 MHz during nonvolatile writes
// (R11) reset time-out is timed by the watchdog oscillator, not the chip clock
// (R12) select code 0011 runs from the 128 kHz oscillator
// (R13) 128 kHz: wake 6 cycles; reset 14, +4 ms, +64 ms
// (R14) select code 0000 runs from the external clock pin
// (R15) external clock: wake 6 cycles; reset 14, +4.1 ms, +65 ms; 11 reserved
// (R16) external clock changes under 2 percent per cycle, else hold reset
// (R17) prescaler resets to 0000, or 0011 with divide-by-eight fuse; freely writable
// (R18) start-up counts run on the chosen source; clock released afterwards
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module ccs_clock_ctrl #(
    parameter int unsigned TICKS_FAST    = ccs_pkg::TICKS_FAST,
    parameter int unsigned TICKS_SLOW    = ccs_pkg::TICKS_SLOW,
    parameter int unsigned TICKS_FAST_LP = ccs_pkg::TICKS_FAST_LP,
    parameter int unsigned TICKS_SLOW_LP = ccs_pkg::TICKS_SLOW_LP
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [ccs_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // fuses and factory byte
    input  wire logic [3:0]               fuse_cksel_i,
    input  wire logic [1:0]               fuse_sut_i,
    input  wire logic                     fuse_reset_pin_disable_fuse_i,
    input  wire logic                     fuse_divide_by_eight_fuse_i,
    input  wire logic [7:0]               factory_cal_i,
    // oscillator ticks and wake event
    input  wire logic [3:0]               src_tick_i,
    input  wire logic                     wdt_tick_i,
    input  wire logic                     wake_event_i,
    // clock system controls
    output logic      [3:0]               src_enable_o,
    output logic                          sys_clk_en_o,
    output logic                          core_reset_o,
    output wire logic [7:0]               trim_o,
    output wire logic                     trim_range_o,
    output wire logic [6:0]               trim_fine_o,
    output logic      [3:0]               prescaler_select_o
);
    localparam int unsigned CW = ccs_pkg::CNT_W;

    // =====================================================================
    // fuse capture
    // =====================================================================
    logic [3:0] cksel_q;
    logic [1:0] sut_q;
    logic       rstdis_q;

    // fuses are sampled while reset is held so a later change cannot upset a phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cksel_q  <= fuse_cksel_i;
            sut_q    <= fuse_sut_i;
            rstdis_q <= fuse_reset_pin_disable_fuse_i;
        end
    end

    ccs_pkg::ccs_src_t src;
    logic              src_tick;
    logic [3:0]        src_onehot;

    ccs_src_decode u_decode (
        .cksel_i    (cksel_q),
        .src_tick_i (src_tick_i),
        .src_o      (src),
        .tick_o     (src_tick),
        .onehot_o   (src_onehot)
    );

    // =====================================================================
    // delay targets
    // =====================================================================
    // wake delay in cycles of the selected source
    function automatic logic [CW-1:0] wake_cycles(ccs_pkg::ccs_src_t s, logic lsb);
        if (s == ccs_pkg::SRC_LFXO) begin
            wake_cycles = lsb ? CW'(ccs_pkg::WAKE_LF_LONG) : CW'(ccs_pkg::WAKE_LF_SHORT); // R01
        end else begin
            wake_cycles = CW'(ccs_pkg::WAKE_INT_CK); // R04 R13 R15
        end
    endfunction

    // extra reset delay in watchdog ticks; reserved code behaves as the slow one
    function automatic logic [CW-1:0] extra_ticks(ccs_pkg::ccs_src_t s, logic [1:0] sut,
                                                  logic rstdis);
        logic lp;
        logic internal;
        lp       = (s == ccs_pkg::SRC_LP128);
        internal = lp || (s == ccs_pkg::SRC_RC);
        if (sut == ccs_pkg::SUT_BOD) begin
            extra_ticks = (rstdis && internal) ? CW'(TICKS_FAST) : '0; // R05
        end else if (sut == ccs_pkg::SUT_FAST) begin
            extra_ticks = lp ? CW'(TICKS_FAST_LP) : CW'(TICKS_FAST); // R02 R04 R13 R15
        end else begin
            extra_ticks = lp ? CW'(TICKS_SLOW_LP) : CW'(TICKS_SLOW); // R02 R04 R13 R15
        end
    endfunction

    ccs_pkg::ccs_state_t state;
    ccs_pkg::ccs_state_t next_state;

    wire [CW-1:0] wake_limit  = wake_cycles(src, cksel_q[0]);
    wire [CW-1:0] extra_limit = extra_ticks(src, sut_q, rstdis_q);
    wire          in_wake     = (state == ccs_pkg::ST_WAKE);
    wire          src_run     = (state == ccs_pkg::ST_RST_CK) || in_wake;
    wire [CW-1:0] src_limit   = in_wake ? wake_limit : CW'(ccs_pkg::RST_BASE_CK);
    wire          wdt_run     = (state == ccs_pkg::ST_RST_TO);
    logic         src_done;
    logic         wdt_done;

    // cycle count on the chosen source itself
    ccs_delay_cnt #(.W(CW)) u_src_cnt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (src_run),
        .tick_i  (src_tick), // R18
        .limit_i (src_limit),
        .done_o  (src_done)
    );

    // reset time-out always on the watchdog oscillator
    ccs_delay_cnt #(.W(CW)) u_wdt_cnt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (wdt_run),
        .tick_i  (wdt_tick_i), // R11
        .limit_i (extra_limit),
        .done_o  (wdt_done)
    );

    // =====================================================================
    // wishbone slave
    // =====================================================================
    logic [7:0] rc_oscillator_trim;
    logic       sleep_pend;

    wire wb_req    = wb_cyc_i && wb_stb_i;
    wire hit_trim  = (wb_adr_i == ccs_pkg::ADDR_TRIM);
    wire hit_presc = (wb_adr_i == ccs_pkg::ADDR_PRESC);
    wire hit_stat  = (wb_adr_i == ccs_pkg::ADDR_STATUS);
    wire hit_ctrl  = (wb_adr_i == ccs_pkg::ADDR_CTRL);
    // writes land on the edge where the master sees ack, only lane 0 carries data
    wire wb_wr     = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    wire wr_trim   = wb_wr && hit_trim;
    wire wr_presc  = wb_wr && hit_presc;
    wire wr_sleep  = wb_wr && hit_ctrl && wb_dat_i[ccs_pkg::CTRL_SLEEP_BIT];

    wire [31:0] status_word = (32'(state) << ccs_pkg::STAT_STATE_LSB)
                            | (32'(src) << ccs_pkg::STAT_SRC_LSB)
                            | (32'(sys_clk_en_o) << ccs_pkg::STAT_REL_BIT)
                            | (32'(sleep_pend) << ccs_pkg::STAT_SLP_BIT);

    // unmapped addresses still answer, reading zero
    wire [31:0] rd_mux = hit_trim  ? 32'(rc_oscillator_trim) :
                         hit_presc ? 32'(prescaler_select_o) :
                         hit_stat  ? status_word :
                         hit_ctrl  ? 32'(sleep_pend) << ccs_pkg::CTRL_SLEEP_BIT : 32'h0;

    // one wait state: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // =====================================================================
    // trim and prescaler registers
    // =====================================================================
    // sync reset, so loading the factory byte here is a plain clocked load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_oscillator_trim <= factory_cal_i; // R06
        end else if (wr_trim) begin
            rc_oscillator_trim <= wb_dat_i[7:0]; // R07
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescaler_select_o <= fuse_divide_by_eight_fuse_i ? ccs_pkg::PRESC_DIV8 : ccs_pkg::PRESC_DIV1; // R17
        end else if (wr_presc) begin
            prescaler_select_o <= wb_dat_i[ccs_pkg::PRESC_W-1:0]; // R17
        end
    end

    // trim drives the oscillator directly, no shadow copy
    assign trim_o       = rc_oscillator_trim; // R07
    assign trim_range_o = rc_oscillator_trim[ccs_pkg::TRIM_RANGE_BIT]; // R08
    assign trim_fine_o  = rc_oscillator_trim[ccs_pkg::TRIM_RANGE_BIT-1:0]; // R09

    // =====================================================================
    // start-up sequencer
    // =====================================================================
    always_comb begin
        next_state = state;
        case (state)
            ccs_pkg::ST_RST_CK: begin
                if (src_done) begin
                    next_state = (extra_limit == '0) ? ccs_pkg::ST_RUN : ccs_pkg::ST_RST_TO;
                end
            end
            ccs_pkg::ST_RST_TO: begin
                if (wdt_done) begin
                    next_state = ccs_pkg::ST_RUN; // R11
                end
            end
            ccs_pkg::ST_RUN: begin
                if (sleep_pend) begin
                    next_state = ccs_pkg::ST_SLEEP;
                end
            end
            ccs_pkg::ST_SLEEP: begin
                if (wake_event_i) begin
                    next_state = ccs_pkg::ST_WAKE;
                end
            end
            ccs_pkg::ST_WAKE: begin
                if (src_done) begin
                    next_state = ccs_pkg::ST_RUN; // R18
                end
            end
            default: begin
                next_state = ccs_pkg::ST_RST_CK;
            end
        endcase
    end

    wire next_run = (next_state == ccs_pkg::ST_RUN);
    wire next_rst = (next_state == ccs_pkg::ST_RST_CK) || (next_state == ccs_pkg::ST_RST_TO);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ccs_pkg::ST_RST_CK;
        end else begin
            state <= next_state;
        end
    end

    // outputs registered from the next state so they line up with the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_clk_en_o <= 1'b0;
            core_reset_o <= 1'b1;
            src_enable_o <= 4'h0;
        end else begin
            sys_clk_en_o <= next_run; // R18
            core_reset_o <= next_rst;
            // oscillator stops in power-down; selection follows the fuses
            src_enable_o <= (next_state == ccs_pkg::ST_SLEEP) ? 4'h0 : src_onehot; // R03 R12 R14
        end
    end

    // request flag set by software, cleared once the sleep is entered; set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_pend <= 1'b0;
        end else if (wr_sleep) begin
            sleep_pend <= 1'b1;
        end else if (state == ccs_pkg::ST_SLEEP) begin
            sleep_pend <= 1'b0;
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // the trim and prescaler reset checks look at reset itself, so the default reset disable must not apply
    a_trim_reset_load: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
        rc_oscillator_trim == $past(factory_cal_i)) else $error("trim not loaded at reset"); // R06
    a_trim_sw_write: assert property (wr_trim |=> trim_o == $past(wb_dat_i[7:0]) &&
        trim_range_o == $past(wb_dat_i[7])) else $error("trim write not applied"); // R07
    a_presc_reset_val: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i && fuse_divide_by_eight_fuse_i |=> prescaler_select_o == ccs_pkg::PRESC_DIV8)
        else $error("prescaler reset wrong"); // R17
    a_clk_held_start: assert property (state != ccs_pkg::ST_RUN |-> !sys_clk_en_o)
        else $error("clock released during start-up"); // R18
    a_rc_default_sel: assert property (cksel_q == ccs_pkg::CKSEL_RC && state == ccs_pkg::ST_RUN
        |-> src_enable_o == 4'h1 << ccs_pkg::SRC_RC) else $error("rc not selected"); // R03
    a_lp_sel: assert property (cksel_q == ccs_pkg::CKSEL_LP128 && state == ccs_pkg::ST_RUN
        |-> src_enable_o == 4'h1 << ccs_pkg::SRC_LP128) else $error("128k not selected"); // R12
    a_ext_sel: assert property (cksel_q == ccs_pkg::CKSEL_EXT && state == ccs_pkg::ST_RUN
        |-> src_enable_o == 4'h1 << ccs_pkg::SRC_EXT) else $error("ext not selected"); // R14
    a_lf_wake_len: assert property (in_wake && src == ccs_pkg::SRC_LFXO |-> src_limit ==
        (cksel_q[0] ? 16'h8000 : 16'h0400)) else $error("lf wake length wrong"); // R01
    a_int_wake_len: assert property (in_wake && src != ccs_pkg::SRC_LFXO |->
        src_limit == 16'h0006) else $error("wake length wrong"); // R04
    a_rstdis_extra: assert property (rstdis_q && sut_q == ccs_pkg::SUT_BOD &&
        src == ccs_pkg::SRC_RC |-> extra_limit == CW'(TICKS_FAST))
        else $error("reset pin disable extra missing"); // R05
    a_wdt_timeout: assert property (wdt_run && !wdt_tick_i |=> state == ccs_pkg::ST_RST_TO)
        else $error("time-out ended without watchdog tick"); // R11
    a_lf_extra_fast: assert property (src == ccs_pkg::SRC_LFXO && sut_q == ccs_pkg::SUT_FAST
        |-> extra_limit == CW'(TICKS_FAST)) else $error("lf extra delay wrong"); // R02

    c_reset_to_run: cover property (state == ccs_pkg::ST_RST_TO ##1 state == ccs_pkg::ST_RUN);
    c_wake_done: cover property (in_wake ##1 state == ccs_pkg::ST_RUN);
    c_trim_write: cover property (wr_trim);
    c_sleep_entry: cover property (wr_sleep ##[1:4] state == ccs_pkg::ST_SLEEP);
endmodule

// ---- pkg/ccs_pkg.sv ----
// constants, codes and types shared by the clock source start-up control block
package ccs_pkg;

    // =====================================================================
    // register map (byte addresses on the wishbone bus)
    // =====================================================================
    localparam int unsigned ADR_W         = 8;
    localparam logic [7:0]  ADDR_TRIM     = 8'h00;
    localparam logic [7:0]  ADDR_PRESC    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS   = 8'h08;
    localparam logic [7:0]  ADDR_CTRL     = 8'h0c;

    // field positions
    localparam int unsigned TRIM_W         = 8;
    localparam int unsigned TRIM_RANGE_BIT = 7;
    localparam int unsigned PRESC_W        = 4;
    localparam int unsigned CTRL_SLEEP_BIT = 0;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_SRC_LSB   = 4;
    localparam int unsigned STAT_REL_BIT   = 8;
    localparam int unsigned STAT_SLP_BIT   = 9;

    // prescaler reset values
    localparam logic [3:0]  PRESC_DIV1 = 4'h0;
    localparam logic [3:0]  PRESC_DIV8 = 4'h3;

    // =====================================================================
    // fuse encodings
    // =====================================================================
    localparam logic [3:0]  CKSEL_EXT     = 4'h0;
    localparam logic [3:0]  CKSEL_RC      = 4'h2;
    localparam logic [3:0]  CKSEL_LP128   = 4'h3;
    localparam logic [2:0]  CKSEL_LFXO_HI = 3'h3;
    localparam logic [1:0]  SUT_BOD       = 2'h0;
    localparam logic [1:0]  SUT_FAST      = 2'h1;
    localparam logic [1:0]  SUT_SLOW      = 2'h2;

    // =====================================================================
    // start-up figures
    // =====================================================================
    localparam int unsigned CNT_W          = 16;
    localparam int unsigned RST_BASE_CK    = 14;
    localparam int unsigned WAKE_LF_SHORT  = 1024;
    localparam int unsigned WAKE_LF_LONG   = 32768;
    localparam int unsigned WAKE_INT_CK    = 6;
    localparam int unsigned WDT_OSC_KHZ    = 128;
    localparam int unsigned T_FAST_US      = 4100;
    localparam int unsigned T_SLOW_US      = 65000;
    localparam int unsigned T_FAST_LP_US   = 4000;
    localparam int unsigned T_SLOW_LP_US   = 64000;
    // least times: round up to whole watchdog ticks
    localparam int unsigned TICKS_FAST    = (T_FAST_US * WDT_OSC_KHZ + 999) / 1000;
    localparam int unsigned TICKS_SLOW    = (T_SLOW_US * WDT_OSC_KHZ + 999) / 1000;
    localparam int unsigned TICKS_FAST_LP = (T_FAST_LP_US * WDT_OSC_KHZ + 999) / 1000;
    localparam int unsigned TICKS_SLOW_LP = (T_SLOW_LP_US * WDT_OSC_KHZ + 999) / 1000;

    // =====================================================================
    // types
    // =====================================================================
    typedef enum logic [1:0] {
        SRC_EXT   = 2'b00,
        SRC_RC    = 2'b01,
        SRC_LP128 = 2'b10,
        SRC_LFXO  = 2'b11
    } ccs_src_t;

    typedef enum logic [2:0] {
        ST_RST_CK = 3'b000,
        ST_RST_TO = 3'b001,
        ST_RUN    = 3'b010,
        ST_SLEEP  = 3'b011,
        ST_WAKE   = 3'b100
    } ccs_state_t;

endpackage

// ---- rtl/ccs_delay_cnt.sv ----
// tick counter that reports the tick completing a programmed count
`timescale 1ns/1ns
module ccs_delay_cnt #(
    parameter int unsigned W = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         run_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] limit_i,
    // result
    output wire logic         done_o
);
    logic [W-1:0] cnt;

    // count restarts whenever run drops, so each phase starts from zero
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt <= '0;
        end else if (tick_i) begin
            cnt <= cnt + 1'b1;
        end
    end

    // limit of zero is never used by the caller
    assign done_o = run_i && tick_i && (cnt == limit_i - 1'b1);
endmodule

// ---- rtl/ccs_src_decode.sv ----
// decodes the source select fuses and picks the tick of that source
`timescale 1ns/1ns
module ccs_src_decode (
    // fuse value
    input  wire logic [3:0]       cksel_i,
    // ticks from the four oscillators, indexed by source code
    input  wire logic [3:0]       src_tick_i,
    // decoded source
    output ccs_pkg::ccs_src_t     src_o,
    output wire logic             tick_o,
    output wire logic [3:0]       onehot_o
);
    // =====================================================================
    // source decode
    // =====================================================================
    wire is_ext  = (cksel_i == ccs_pkg::CKSEL_EXT);
    wire is_lp   = (cksel_i == ccs_pkg::CKSEL_LP128);
    wire is_lfxo = (cksel_i[3:1] == ccs_pkg::CKSEL_LFXO_HI);

    // codes not handled here fall back to the rc oscillator so the part still runs
    assign src_o = is_ext  ? ccs_pkg::SRC_EXT   :
                   is_lp   ? ccs_pkg::SRC_LP128 :
                   is_lfxo ? ccs_pkg::SRC_LFXO  : ccs_pkg::SRC_RC;

    assign tick_o   = src_tick_i[src_o];
    assign onehot_o = 4'h1 << src_o;
endmodule

// ---- dv/ccs_osc_model.sv ----
// oscillator tick model: four source pulse trains and the watchdog pulse train
`timescale 1ns/1ns
module ccs_osc_model (
    // clock
    input  wire logic       clk_i,
    // ticks
    output logic      [3:0] src_tick_o,
    output logic            wdt_tick_o
);
    // =====================================================================
    // steady 12-cycle frame; no period ever changes between cycles
    // watchdog at phase 5 never meets a source tick or the edge after one
    int unsigned ph = 0;
    always_ff @(posedge clk_i) begin
        ph <= (ph + 1) % 12;
    end
    assign src_tick_o = {ph % 3 == 0, ph == 0, ph % 6 == 0, ph % 3 == 0};
    assign wdt_tick_o = (ph == 5);
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the clock source start-up control block
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wake = 0;
    logic        rstdis = 0, div8 = 0, ack, sys_en, core_rst, trng, wtick;
    logic [7:0]  adr = 0, cal = 0, trim, v;
    logic [3:0]  sel = 0, cksel = 0, src_en, presc, stick, p;
    logic [1:0]  sut = 0;
    logic [6:0]  tfine;
    logic [31:0] wdat = 0, rdat, q;
    // 8'h72 is the 32K lf wake; the next entry resets it in mid-wake
    logic [7:0]  cfgs [14] = '{8'h21, 8'h22, 8'h24, 8'h29, 8'h2c, 8'h32, 8'h34,
                              8'h39, 8'h02, 8'h05, 8'h08, 8'h62, 8'h72, 8'h65};
    int          mismatches = 0, total_checks = 0, sc, s, w, lim;

    // =====================================================================
    // clock, design and oscillators
    always #20 clk_i = ~clk_i;
    ccs_clock_ctrl #(.TICKS_FAST(3), .TICKS_SLOW(5), .TICKS_FAST_LP(2), .TICKS_SLOW_LP(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .fuse_cksel_i(cksel), .fuse_sut_i(sut), .fuse_reset_pin_disable_fuse_i(rstdis),
        .fuse_divide_by_eight_fuse_i(div8), .factory_cal_i(cal), .src_tick_i(stick), .wdt_tick_i(wtick),
        .wake_event_i(wake), .src_enable_o(src_en), .sys_clk_en_o(sys_en),
        .core_reset_o(core_rst), .trim_o(trim), .trim_range_o(trng), .trim_fine_o(tfine),
        .prescaler_select_o(presc));
    ccs_osc_model osc (.clk_i(clk_i), .src_tick_o(stick), .wdt_tick_o(wtick));

    // =====================================================================
    // reference model: source code and extra watchdog ticks from the fuses
    function automatic int code(input logic [3:0] c);
        if (c[3:1] == 3'h3) return 3;
        return (c == ccs_pkg::CKSEL_EXT) ? 0 : (c == ccs_pkg::CKSEL_LP128) ? 2 : 1;
    endfunction
    function automatic int extra(input logic [3:0] c, input logic [1:0] t, input logic r);
        bit lp;
        lp = (c == ccs_pkg::CKSEL_LP128);
        if (t == 2'h0) return ((c == ccs_pkg::CKSEL_RC || lp) && r) ? 3 : 0;
        return (t == 2'h1) ? (lp ? 2 : 3) : (lp ? 4 : 5);
    endfunction

    // =====================================================================
    // closing, bus cycle and tick counting
    task automatic test_done;
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // entered right after a rising edge; leaves one idle cycle behind
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1;
        stb <= 1;
        we <= wr;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        // no cycle count assumed: only the bench watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask
    // source ticks up to lim, then watchdog ticks, until the clock is released or 6000 cycles pass
    task automatic count(input int lim);
        s = 0;
        w = 0;
        repeat (6000) begin
            @(posedge clk_i);
            if (sys_en === 1'b1) break;
            if (s >= lim && wtick) w++;
            if (s < lim && stick[sc]) s++;
        end
    endtask

    // =====================================================================
    // watchdog: the whole table needs about 15k cycles, so allow 30k
    initial begin
        #1200000;
        mismatches++;
        test_done();
    end

    // =====================================================================
    // main sequence: one reset, start-up, register and sleep pass per fuse set
    initial begin
        void'($urandom(41));
        foreach (cfgs[i]) begin
            @(posedge clk_i);
            {cksel, sut, rstdis, div8} <= cfgs[i];
            cal <= 8'($urandom);
            rst_i <= 1;
            repeat (10) @(posedge clk_i);
            `CHK(trim, cal)
            `CHK(presc, div8 ? ccs_pkg::PRESC_DIV8 : ccs_pkg::PRESC_DIV1)
            `CHK(core_rst, 1'b1)
            `CHK(sys_en, 1'b0)
            rst_i <= 0;
            sc = code(cksel);
            count(14);
            `CHK(s, 14)
            `CHK(core_rst, 1'b0)
            `CHK(w, extra(cksel, sut, rstdis))
            `CHK(src_en, 4'h1 << sc)
            wb(0, ccs_pkg::ADDR_STATUS, 0);
            `CHK(q[5:4], sc[1:0])
            `CHK(q[8], 1'b1)
            // no nonvolatile write runs here, so any trim value is allowed
            v = 8'($urandom);
            wb(1, ccs_pkg::ADDR_TRIM, {24'h0, v});
            `CHK(trim, v)
            `CHK({trng, tfine}, v)
            wb(0, ccs_pkg::ADDR_TRIM, 0);
            `CHK(q, {24'h0, v})
            p = 4'($urandom);
            wb(1, ccs_pkg::ADDR_PRESC, {28'h0, p});
            wb(0, ccs_pkg::ADDR_PRESC, 0);
            `CHK(q[3:0], p)
            wb(1, 8'h10, 32'hff);
            wb(0, 8'h10, 0);
            `CHK(q, 32'h0)
            wb(1, ccs_pkg::ADDR_CTRL, 32'h1);
            repeat (3) @(posedge clk_i);
            `CHK(src_en, 4'h0)
            repeat ($urandom_range(0, 7)) @(posedge clk_i);
            wake <= 1;
            @(posedge clk_i);
            wake <= 0;
            lim = (sc == 3) ? (cksel[0] ? 32768 : 1024) : 6;
            count(lim);
            // a 32K wake outlasts the 6000-cycle window: 2000 lf ticks, no release yet
            `CHK(s, (lim > 2000) ? 2000 : lim)
            `CHK(sys_en, lim <= 2000)
        end
        test_done();
    end
endmodule
